// ---- hw/atl_pkg.sv ----
// shared constants, register map and types of the adc trigger and limit block
package atl_pkg;
  // clock and timing
  localparam int unsigned CLK_MHZ       = 40;     // pclk rate
  localparam int unsigned T_ATRIG_NS    = 50000;  // periodic trigger interval
  localparam int unsigned T_SAMPLE_NS   = 200;    // least sampling time
  localparam int unsigned T_SETTLE_NS   = 100;    // least settle per bit
  localparam int unsigned ATRIG_CYC     = T_ATRIG_NS * CLK_MHZ / 1000;
  localparam int unsigned SAMPLE_CYC    = (T_SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_CYC    = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
  // register byte offsets
  localparam logic [11:0] ADR_CMD       = 12'h000;
  localparam logic [11:0] ADR_CTRL      = 12'h004;
  localparam logic [11:0] ADR_CFG       = 12'h008;
  localparam logic [11:0] ADR_LIM       = 12'h00c;
  localparam logic [11:0] ADR_RES       = 12'h010;
  localparam logic [11:0] ADR_ERR       = 12'h014;
  localparam logic [11:0] ADR_STAT      = 12'h018;
  // field positions
  localparam int unsigned CMD_CONV      = 0;
  localparam int unsigned CMD_CLEAR_STATUS_COMMAND      = 1;
  localparam int unsigned CMD_EXIT      = 2;
  localparam int unsigned CTRL_UNLOCK   = 0;
  localparam int unsigned CTRL_TPEN     = 1;
  localparam int unsigned CTRL_REACT    = 2;
  localparam int unsigned CFG_ATS       = 0;
  localparam int unsigned CFG_EDGE      = 2;
  localparam int unsigned CFG_CSE       = 3;
  localparam int unsigned CFG_GS        = 4;
  localparam int unsigned CFG_OS        = 6;
  localparam int unsigned CFG_DLY       = 8;
  localparam int unsigned LIM_LO        = 0;
  localparam int unsigned LIM_HI        = 8;
  localparam int unsigned RES_VALID     = 8;
  localparam int unsigned ERR_UNDER     = 0;
  localparam int unsigned ERR_OVER      = 1;
  localparam int unsigned ERR_VIOL      = 2;
  localparam int unsigned STAT_BUSY     = 0;
  localparam int unsigned STAT_FROZEN   = 1;
  // reset values: limits wide open so no flag can rise
  localparam logic [5:0]  LIM_LO_RST    = 6'h00;
  localparam logic [5:0]  LIM_HI_RST    = 6'h3f;
  // trigger source select encodings
  typedef enum logic [1:0] {
    ATS_OFF = 2'h0, ATS_PER = 2'h1, ATS_PWM = 2'h2, ATS_RSV = 2'h3
  } atl_ats_t;
  // extended compare values of the limit fields
  function automatic logic [7:0] atl_ext_lo(input logic [5:0] f);
    return {f, 2'h0};
  endfunction
  function automatic logic [7:0] atl_ext_hi(input logic [5:0] f);
    return {f, 2'h3};
  endfunction
endpackage

// ---- hw/atl_edge.sv ----
// pin synchroniser with registered rising and falling edge pulses
`timescale 1ns/1ps
module atl_edge (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  // whole module state
  typedef struct packed {
    logic s1;    // first sync stage, read only by s2
    logic s2;    // second sync stage
    logic s3;    // previous synced level
    logic rise;  // one-cycle rising pulse
    logic fall;  // one-cycle falling pulse
  } atl_edge_st_t;
  atl_edge_st_t q;
  atl_edge_st_t next_q;

  // next state
  always_comb begin
    next_q      = q;
    next_q.s1   = pin;
    next_q.s2   = q.s1;
    next_q.s3   = q.s2;
    next_q.rise = q.s2 & ~q.s3;
    next_q.fall = ~q.s2 & q.s3;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rise = q.rise;
  assign fall = q.fall;
endmodule

// ---- hw/atl_sar.sv ----
// successive approximation sequencer for the 8-bit converter
`timescale 1ns/1ps
module atl_sar
  import atl_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic       cmp_in,
  output logic            busy,
  output logic            done,
  output logic [7:0]      code,
  output logic            sample_hold
);
  // gray along idle -> sample -> bits
  typedef enum logic [1:0] {
    SAR_IDLE = 2'h0, SAR_SAMPLE = 2'h1, SAR_BIT = 2'h3
  } atl_sar_fsm_t;
  typedef struct packed {
    atl_sar_fsm_t state;
    logic [7:0]   cnt;   // sample / settle counter
    logic [2:0]   bitp;  // bit under trial
    logic [7:0]   code;  // trial code to the dac, final code at done
    logic         done;
    logic         hold;
    logic         c1;    // comparator sync, read only by c2
    logic         c2;
  } atl_sar_st_t;
  atl_sar_st_t q;
  atl_sar_st_t next_q;

  // settle must exceed the two-stage comparator sync latency
  always_comb begin
    next_q      = q;
    next_q.done = 1'b0;
    next_q.c1   = cmp_in;
    next_q.c2   = q.c1;
    case (q.state)
      SAR_IDLE: begin
        if (start) begin
          next_q.state = SAR_SAMPLE;
          next_q.cnt   = 8'h00;
          next_q.hold  = 1'b1;
          next_q.code  = 8'h00;
        end
      end
      SAR_SAMPLE: begin
        if (q.cnt == 8'(SAMPLE_CYCLES - 1)) begin
          next_q.hold  = 1'b0;
          next_q.state = SAR_BIT;
          next_q.bitp  = 3'h7;
          next_q.code  = 8'h80;
          next_q.cnt   = 8'h00;
        end else begin
          next_q.cnt = q.cnt + 8'h01;
        end
      end
      SAR_BIT: begin
        if (q.cnt == 8'(SETTLE_CYCLES - 1)) begin
          next_q.cnt = 8'h00;
          // comparator low: input below trial, drop the bit
          if (!q.c2) begin
            next_q.code[q.bitp] = 1'b0;
          end
          if (q.bitp == 3'h0) begin
            next_q.state = SAR_IDLE;
            next_q.done  = 1'b1;
          end else begin
            next_q.bitp = q.bitp - 3'h1;
            next_q.code[3'(q.bitp - 3'h1)] = 1'b1;
          end
        end else begin
          next_q.cnt = q.cnt + 8'h01;
        end
      end
      default: begin
        next_q.state = SAR_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign busy        = (q.state != SAR_IDLE);
  assign done        = q.done;
  assign code        = q.code;
  assign sample_hold = q.hold;
endmodule

// ---- hw/atl_top.sv ----
// adc trigger, result latch and limit check with apb register access
`timescale 1ns/1ps
module atl_top
  import atl_pkg::*;
#(
  parameter int unsigned ATRIG_CYCLES = ATRIG_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_trigger_pin,
  input  wire logic        pwm_hard_level,
  input  wire logic        cmp_in,
  output logic             sample_hold,
  output logic      [7:0]  dac_code,
  output logic             current_source_enable,
  output logic      [1:0]  gain_select,
  output logic      [1:0]  offset_select,
  output logic             fault_a_notify_output_n
);
  localparam int unsigned PW = $clog2(ATRIG_CYCLES + 1);

  // whole block state
  typedef struct packed {
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic          unlock;    // converter_config_unlock
    logic          frozen;    // set by leave_configuration_command
    logic          tpen;      // trigger_pin_enable
    logic          react;     // limit_event_reaction_enable
    atl_ats_t      trigger_source_select;       // trigger_source_select
    logic          edge_fall; // pwm edge: 1 falling, 0 rising
    logic          cse;       // current_source_enable
    logic [1:0]    gs;        // gain_select
    logic [1:0]    os;        // offset_select
    logic [7:0]    dly;       // pwm_trigger_delay in pclk cycles
    logic [5:0]    lo;        // lower_limit_field
    logic [5:0]    hi;        // upper_limit_field
    logic [7:0]    result;    // conversion_result_value
    logic          valid;     // result_valid_flag
    logic          under;     // under_limit_error
    logic          over;      // over_limit_error
    logic          viol;      // limit_violation_status
    logic          fault_n;   // fault_a_notify_output_n
    logic [PW-1:0] per_cnt;   // periodic interval counter
    logic          dly_run;   // pwm delay in progress
    logic [7:0]    dly_cnt;
    logic          start;     // one-cycle start to the sequencer
  } atl_state_t;
  atl_state_t q;
  atl_state_t next_q;

  // byte-lane merge of a write into a register image
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic        setup;      // apb setup cycle
  logic        wr;         // write completes this edge
  logic        cfg_ok;     // static config writable
  logic        cmd_conv;   // conversion request command
  logic        cmd_clear_status_command;   // clear_status_command
  logic        cmd_exit;   // leave_configuration_command
  logic        ext_rise;
  logic        pwm_rise;
  logic        pwm_fall;
  logic        pwm_edge;
  logic        per_fire;
  logic        dly_fire;
  logic        trig_any;
  logic        sar_busy;
  logic        sar_done;
  logic [7:0]  sar_code;
  logic        under_c;
  logic        over_c;
  logic [31:0] cur_ctrl;
  logic [31:0] cur_cfg;
  logic [31:0] cur_lim;
  logic [31:0] ctrl_w;
  logic [31:0] cfg_w;
  logic [31:0] lim_w;
  logic [31:0] rd_word;
  logic        rd_err;

  // external trigger pin, synchronised
  atl_edge u_ext (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (external_trigger_pin),
    .rise    (ext_rise),
    .fall    ()
  );

  // hard on/off level of the output stage, not the plateau level
  atl_edge u_pwm (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (pwm_hard_level),
    .rise    (pwm_rise),
    .fall    (pwm_fall)
  );

  atl_sar u_sar (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (q.start),
    .cmp_in      (cmp_in),
    .busy        (sar_busy),
    .done        (sar_done),
    .code        (dac_code),
    .sample_hold (sample_hold)
  );
  assign sar_code = dac_code;

  // bus decode; pready is registered so each access has one wait-free beat
  assign setup    = psel & ~penable;
  assign wr       = psel & penable & q.pready & pwrite;
  assign cfg_ok   = q.unlock & ~q.frozen;
  assign cmd_conv = wr && paddr == ADR_CMD && pstrb[0] && pwdata[CMD_CONV];
  assign cmd_clear_status_command = wr && paddr == ADR_CMD && pstrb[0] && pwdata[CMD_CLEAR_STATUS_COMMAND];
  assign cmd_exit = wr && paddr == ADR_CMD && pstrb[0] && pwdata[CMD_EXIT];

  // register images
  assign cur_ctrl = {29'h0, q.react, q.tpen, q.unlock};
  assign cur_cfg  = {16'h0, q.dly, q.os, q.gs, q.cse, q.edge_fall, q.trigger_source_select};
  assign cur_lim  = {18'h0, q.hi, 2'h0, q.lo};
  assign ctrl_w   = wmerge(cur_ctrl, pwdata, pstrb);
  assign cfg_w    = wmerge(cur_cfg, pwdata, pstrb);
  assign lim_w    = wmerge(cur_lim, pwdata, pstrb);

  // extended limits; below both, above both
  assign under_c  = sar_code < atl_ext_lo(q.lo) &&
                    sar_code < atl_ext_hi(q.hi);
  assign over_c   = sar_code > atl_ext_lo(q.lo) &&
                    sar_code > atl_ext_hi(q.hi);

  // periodic trigger at end of each interval
  assign per_fire = q.trigger_source_select == ATS_PER && q.per_cnt == PW'(ATRIG_CYCLES - 1);
  assign pwm_edge = q.edge_fall ? pwm_fall : pwm_rise;
  assign dly_fire = q.dly_run && q.dly_cnt == q.dly;
  assign trig_any = cmd_conv | (ext_rise & q.tpen) | per_fire | dly_fire;

  // read mux and error decode for the setup cycle
  always_comb begin
    rd_word = 32'h0;
    rd_err  = 1'b0;
    case (paddr)
      ADR_CMD: begin
        rd_word = 32'h0;
      end
      ADR_CTRL: begin
        rd_word = cur_ctrl;
        rd_err  = pwrite & q.frozen;
      end
      ADR_CFG: begin
        rd_word = cur_cfg;
        rd_err  = pwrite & ~cfg_ok;
      end
      ADR_LIM: begin
        rd_word = cur_lim;
        rd_err  = pwrite & ~cfg_ok;
      end
      ADR_RES: begin
        rd_word = 32'h0;
        rd_word[7:0] = q.result;
        rd_word[RES_VALID] = q.valid;
      end
      ADR_ERR: begin
        rd_word[ERR_UNDER] = q.under;
        rd_word[ERR_OVER]  = q.over;
        rd_word[ERR_VIOL]  = q.viol;
      end
      ADR_STAT: begin
        rd_word[STAT_BUSY]   = sar_busy;
        rd_word[STAT_FROZEN] = q.frozen;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // next state of the whole block
  always_comb begin
    next_q         = q;
    next_q.pready  = setup;
    next_q.pslverr = setup & rd_err;
    if (setup) begin
      next_q.prdata = pwrite ? 32'h0 : rd_word;
    end
    // start only when the sequencer is idle
    next_q.start = trig_any & ~sar_busy & ~q.start;
    // periodic counter runs only in periodic mode
    if (q.trigger_source_select != ATS_PER || per_fire) begin
      next_q.per_cnt = '0;
    end else begin
      next_q.per_cnt = q.per_cnt + PW'(1);
    end
    // delay restarts on each hard transition of the selected edge
    if (q.trigger_source_select != ATS_PWM) begin
      next_q.dly_run = 1'b0;
    end else if (pwm_edge) begin
      next_q.dly_run = 1'b1;
      next_q.dly_cnt = 8'h00;
    end else if (dly_fire) begin
      next_q.dly_run = 1'b0;
    end else if (q.dly_run) begin
      next_q.dly_cnt = q.dly_cnt + 8'h01;
    end
    // control bits only while not frozen
    if (wr && paddr == ADR_CTRL && !q.frozen) begin
      next_q.unlock = ctrl_w[CTRL_UNLOCK];
      next_q.tpen   = ctrl_w[CTRL_TPEN];
      next_q.react  = ctrl_w[CTRL_REACT];
    end
    if (wr && paddr == ADR_CFG && cfg_ok) begin
      next_q.trigger_source_select       = atl_ats_t'(cfg_w[CFG_ATS +: 2]);
      next_q.edge_fall = cfg_w[CFG_EDGE];
      next_q.cse       = cfg_w[CFG_CSE];
      next_q.gs        = cfg_w[CFG_GS +: 2];
      next_q.os        = cfg_w[CFG_OS +: 2];
      next_q.dly       = cfg_w[CFG_DLY +: 8];
    end
    if (wr && paddr == ADR_LIM && cfg_ok) begin
      next_q.lo = lim_w[LIM_LO +: 6];
      next_q.hi = lim_w[LIM_HI +: 6];
    end
    if (cmd_exit) begin
      next_q.frozen = 1'b1;
      next_q.unlock = 1'b0;
    end
    // clear first so a same-cycle completion still sets
    if (cmd_clear_status_command) begin
      next_q.valid   = 1'b0;
      next_q.under   = 1'b0;
      next_q.over    = 1'b0;
      next_q.fault_n = 1'b1;
    end
    // result and valid together; result held until next completion, valid until a clear
    if (sar_done) begin
      next_q.result = sar_code;
      next_q.valid  = 1'b1;
      // checked on each result, in range leaves under and over, clears viol
      if (under_c) begin
        next_q.under = 1'b1;
      end
      if (over_c) begin
        next_q.over = 1'b1;
      end
      next_q.viol = under_c | over_c;
      // fault on violation rise when enabled
      if (q.react && (under_c || over_c) && !q.viol) begin
        next_q.fault_n = 1'b0;
      end
    end
  end

  // state register; limits open after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.lo      <= LIM_LO_RST;
      q.hi      <= LIM_HI_RST;
      q.fault_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign prdata                  = q.prdata;
  assign pready                  = q.pready;
  assign pslverr                 = q.pslverr;
  assign current_source_enable   = q.cse;
  assign gain_select             = q.gs;
  assign offset_select           = q.os;
  assign fault_a_notify_output_n = q.fault_n;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // start pulse only ever reaches an idle sequencer
  property p_drop_busy;
    q.start |-> !sar_busy;
  endproperty
  a_drop_busy: assert property (p_drop_busy)
    else $error("start issued while busy");
  property p_result;
    sar_done |=> q.valid && q.result == $past(sar_code);
  endproperty
  a_result: assert property (p_result)
    else $error("result or valid not latched");
  property p_hold;
    q.valid && !cmd_clear_status_command |=> q.valid && $stable(q.result) || $past(sar_done);
  endproperty
  a_hold: assert property (p_hold)
    else $error("valid or result lost");
  property p_under;
    sar_done && under_c && !cmd_clear_status_command
      |=> q.under && !q.over == !$past(q.over);
  endproperty
  a_under: assert property (p_under)
    else $error("under flag not set");
  property p_over;
    sar_done && over_c && !under_c |=> q.over;
  endproperty
  a_over: assert property (p_over)
    else $error("over flag not set");
  property p_inside;
    sar_done && !under_c && !over_c && !cmd_clear_status_command
      |=> $stable(q.under) && $stable(q.over) && !q.viol;
  endproperty
  a_inside: assert property (p_inside)
    else $error("flag changed for in-range result");
  property p_lock;
    wr && paddr == ADR_CFG && !cfg_ok |=> $stable(cur_cfg);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked config changed");
  property p_frozen;
    q.frozen |=> q.frozen && !q.unlock;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("frozen config reopened");
  property p_pin;
    ext_rise && q.tpen && !sar_busy && !q.start |=> q.start ##1 sar_busy;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin edge did not start conversion");
  property p_fault;
    sar_done && q.react && !q.viol && (under_c || over_c)
      |=> !fault_a_notify_output_n;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault output not asserted");

  c_conv:  cover property (q.start ##[1:200] sar_done);
  c_drop:  cover property (sar_busy && trig_any);
  c_under: cover property (sar_done && under_c);
  c_fault: cover property ($fell(fault_a_notify_output_n));
endmodule

// ---- tb/atl_afe_model.sv ----
// behavioural analogue front end: sample capacitor and comparator
`timescale 1ns/1ps
module atl_afe_model (
  input  wire logic       pclk,
  input  wire logic       sample_hold,
  input  wire logic [7:0] dac_code,
  input  var  int         vin_diff,
  output logic            cmp_in
);
  logic [7:0] held = 8'h00; // level held on the sampling cap

  function automatic logic [7:0] clampv(input int v);
    return v < 0 ? 8'h00 : (v > 255 ? 8'hff : 8'(v));
  endfunction

  always @(posedge pclk) begin
    if (sample_hold) begin
      held <= clampv(vin_diff);
    end
  end

  // comparator: 1 keeps the trial bit
  assign cmp_in = held >= dac_code;
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the adc trigger and limit block
`timescale 1ns/1ps
module tb;
  import atl_pkg::*;
  logic        pclk                    = 1'b0;
  logic        presetn                 = 1'b0;
  logic [11:0] paddr                   = 12'h000;
  logic        psel                    = 1'b0;
  logic        penable                 = 1'b0;
  logic        pwrite                  = 1'b0;
  logic [31:0] pwdata                  = 32'h0;
  logic [3:0]  pstrb                   = 4'hf;
  logic        external_trigger_pin    = 1'b0;
  logic        pwm_hard_level          = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmp_in;
  logic        sample_hold;
  logic [7:0]  dac_code;
  logic        current_source_enable;
  logic [1:0]  gain_select;
  logic [1:0]  offset_select;
  logic        fault_a_notify_output_n;
  int          vin = 0;        // differential input in codes
  int          fail_count = 0;
  int          checks_done = 0;
  logic [7:0]  lfsr = 8'h12;   // fixed seed
  logic [31:0] rd;             // last read data
  logic        er;             // last slave error
  logic [31:0] e;              // expected error word
  logic        pbad;           // previous result out of range
  int          n;
  int          v;
  int          corner [7] = '{0, -5, 300, 'h3f, 'h40, 'h83, 'h84};

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // short periodic interval keeps the run brief
  atl_top #(.ATRIG_CYCLES(20)) dut (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .external_trigger_pin, .pwm_hard_level, .cmp_in, .sample_hold,
    .dac_code, .current_source_enable, .gain_select, .offset_select,
    .fault_a_notify_output_n);

  atl_afe_model afe (.pclk, .sample_hold, .dac_code, .vin_diff(vin),
    .cmp_in);

  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // expected code: input clamped to the code range
  function automatic logic [7:0] xres(input int x);
    return x < 0 ? 8'h00 : (x > 255 ? 8'hff : 8'(x));
  endfunction

  // expected error word from extended limits
  function automatic logic [31:0] xerr(input logic [7:0] r,
                                       input logic [5:0] lo,
                                       input logic [5:0] hi);
    logic u;
    logic o;
    u = r < {lo, 2'h0};
    o = r > {hi, 2'h3};
    return {29'h0, u | o, o, u};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look at pready between edges, where it has settled
    do begin
      @(negedge pclk);
    end while (pready !== 1'b1);
    // answer stands until the edge that ends the access
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll the result register until valid, bounded
  task automatic wait_valid;
    n = 0;
    do begin
      apb(1'b0, ADR_RES, 32'h0);
      n++;
    end while (rd[RES_VALID] !== 1'b1 && n < 80);
  endtask

  task automatic conv(input int x);
    vin <= x;
    apb(1'b1, ADR_CMD, 32'h1);
    wait_valid();
  endtask

  task automatic clr;
    apb(1'b1, ADR_CMD, 32'h2);
  endtask

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog, far beyond the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADR_LIM, 32'h0);
    chk(rd, 32'h3f00);
    chk({fault_a_notify_output_n, current_source_enable, gain_select,
         offset_select}, 32'h20);
    apb(1'b0, 12'h01c, 32'h0);
    chk(er, 1'b1);
    // limits locked until unlock bit set
    apb(1'b1, ADR_LIM, 32'h2010);
    chk(er, 1'b1);
    apb(1'b0, ADR_LIM, 32'h0);
    chk(rd, 32'h3f00);
    // pin ignored while its enable is clear
    external_trigger_pin <= 1'b1;
    repeat (60) @(posedge pclk);
    external_trigger_pin <= 1'b0;
    apb(1'b0, ADR_RES, 32'h0);
    chk(rd, 32'h0);
    conv(255);
    chk(rd, 32'h1ff);
    apb(1'b0, ADR_ERR, 32'h0);
    chk(rd, 32'h0);
    clr();
    endt("reset");
    apb(1'b1, ADR_CTRL, 32'h7);
    apb(1'b1, ADR_CFG, 32'h68);
    // lower limit kept below upper
    apb(1'b1, ADR_LIM, 32'h2010);
    chk({current_source_enable, gain_select, offset_select}, 5'h19);
    // corners first, then random codes
    pbad = 1'b0;
    for (int i = 0; i < 14; i++) begin
      lfsr = lf(lfsr);
      v = i < 7 ? corner[i] : int'(lfsr);
      conv(v);
      chk(rd, {23'h0, 1'b1, xres(v)});
      chk(dac_code, xres(v));
      e = xerr(xres(v), 6'h10, 6'h20);
      apb(1'b0, ADR_ERR, 32'h0);
      chk(rd, e);
      chk(fault_a_notify_output_n, !(e[2] && !pbad));
      pbad = e[2];
      clr();
      apb(1'b0, ADR_RES, 32'h0);
      chk(rd, {24'h0, xres(v)});
    end
    endt("limits");
    // request during a running conversion is dropped
    vin <= 'h11;
    apb(1'b1, ADR_CMD, 32'h1);
    repeat (12) @(posedge pclk);
    vin <= 'h22;
    apb(1'b1, ADR_CMD, 32'h1);
    wait_valid();
    chk(rd, 32'h111);
    clr();
    repeat (60) @(posedge pclk);
    apb(1'b0, ADR_RES, 32'h0);
    chk(rd, 32'h011);
    vin <= 'h33;
    external_trigger_pin <= 1'b1;
    wait_valid();
    external_trigger_pin <= 1'b0;
    chk(rd, 32'h133);
    clr();
    endt("triggers");
    // pwm edge, rising then falling, delay of 10
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, ADR_CFG, 32'(32'h0a62 + 4 * k));
      vin <= 'h44 + k;
      pwm_hard_level <= !pwm_hard_level;
      // outputs launched at the write edge are read once settled
      @(negedge pclk);
      chk(current_source_enable, 1'b0);
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (sample_hold !== 1'b1 && n < 40);
      chk(n >= 11 && n <= 18, 1'b1);
      wait_valid();
      chk(rd, 32'(32'h144 + k));
      clr();
    end
    endt("pwm");
    // every trigger source code; only periodic self-starts
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, ADR_CFG, 32'(32'h60 + s));
      repeat (60) @(posedge pclk);
      clr();
      repeat (150) @(posedge pclk);
      apb(1'b0, ADR_RES, 32'h0);
      chk(rd[RES_VALID], s == 1);
    end
    endt("sources");
    // reaction disabled: a violation leaves the fault output high
    apb(1'b1, ADR_CTRL, 32'h3);
    conv(0);
    chk(fault_a_notify_output_n, 1'b1);
    clr();
    // leave configuration freezes settings
    apb(1'b1, ADR_CMD, 32'h4);
    apb(1'b1, ADR_CFG, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, ADR_CFG, 32'h0);
    chk(rd, 32'h63);
    apb(1'b0, ADR_STAT, 32'h0);
    chk(rd[STAT_FROZEN], 1'b1);
    endt("freeze");
    give_verdict();
  end
endmodule
